/* shared/sief_pkg.sv */
// constants, carriers and enums for the signal integrity error flag block
// assumes a single 100 MHz clock and a synchronous active-high reset
//
// Contract
// R1: detected conditions latch as flags until cleared
// R2: OR of flags drives error pin
// R3: flags latched unless latch disable set
// R4: sensors pass programmable suppression delay filter
// R5: isolation stage active suppresses sensor indications
// R6: clamp conduction sets clamp flag
// R7: near-rail input sets overvoltage flag
// R8: gain network overcurrent sets overload flag
// R9: output clip or overcurrent sets output flag
// R10: checksum flag only while checksum enabled; code gates setting only, a latched flag stays
// R11: diagnostic switches set only by port writes
// R12: switches: short, disconnect, current, discharge, single-pin
// R13: internal 1 MHz timing, optionally driven out
// R14: external pin clock replaces internal oscillator
// R15: selected timing clock divided before use
// R16: present condition beats same-cycle clear
// R17: write one clears flag, zero keeps
// R18: busy bit reads active while isolation on
// R19: extra flag for input amplifier clipping
// R20: resets disable checksum mode
package sief_pkg;

	localparam int unsigned CLK_HZ       = 100_000_000;
	localparam int unsigned OSC_HZ       = 1_000_000;
	localparam int unsigned OSC_HALF_CYC = CLK_HZ / OSC_HZ / 2;
	localparam int unsigned SENSE_W      = 6;
	localparam int unsigned DELAY_W      = 8;
	localparam int unsigned SW_W         = 5;

	// bit positions inside the flag vector
	localparam int unsigned B_OVERVOLT = 0;
	localparam int unsigned B_GAIN     = 1;
	localparam int unsigned B_OUTPUT   = 2;
	localparam int unsigned B_CLAMP    = 3;
	localparam int unsigned B_IACLIP   = 4;
	localparam int unsigned B_CHECKSUM = 5;

	localparam logic [SENSE_W-1:0] FLAGS_RST = 6'h00;
	localparam logic [SW_W-1:0]    SW_RST    = 5'h00;
	localparam logic [DELAY_W-1:0] DELAY_RST = 8'h00;

	typedef struct packed {
		logic input_amp_clip_flag;
		logic clamp_conduction_flag;
		logic output_stage_fault_flag;
		logic gain_network_overload_flag;
		logic input_overvoltage_flag;
	} sief_sense_s;

	typedef struct packed {
		logic single_pin_meas;
		logic discharge;
		logic test_current;
		logic disconnect;
		logic short_to_gnd;
	} sief_switch_s;

	typedef enum logic [1:0] {
		SIEF_CLK_INTERNAL,
		SIEF_CLK_DRIVE_OUT,
		SIEF_CLK_EXTERNAL
	} sief_clkmode_e;

endpackage : sief_pkg

/* testbench/sief_host_model.sv */
// host side model: write-one-to-clear requests on the flag port
// assumes the bench raises go for one cycle, changed at falling edges
`timescale 1ns/10ps
module sief_host_model
	import sief_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               go,
	input  wire logic [SENSE_W-1:0] mask,
	output logic                    wr_clear,
	output logic [SENSE_W-1:0]      wr_clear_mask
);
	initial begin
		wr_clear = 1'b0;
		wr_clear_mask = 6'h00;
	end
	// idle mask is inverted so a stale value cannot look valid
	always @(posedge clk) begin
		wr_clear      <= go;
		wr_clear_mask <= go ? mask : ~wr_clear_mask;
	end
endmodule : sief_host_model

/* testbench/tb_top.sv */
// self-checking bench for the error flag core
// assumes the host model drives the clear port; one 100 MHz clock
`timescale 1ns/10ps
module tb_top;
	import sief_pkg::*;
	logic       clk, rst, cb, iso, srst, wce, wcv, wd, ws, ld, pe;
	logic       g6, go, bz, ep, ce, g6o, g6e, tk, wcl, p;
	logic [4:0] sv, wsv, sw;
	logic [5:0] msk, fl, wcm, ef;
	logic [7:0] wdv, sd;
	sief_clkmode_e cm;
	int num_errors = 0, total_checks = 0, seed = 26851, cyc = 0, n, m;

	sief_core DUT (.clk, .rst, .sense_raw(sv), .checksum_bad(cb),
		.isolation_stage_active(iso), .soft_reset_command(srst),
		.wr_checksum_en(wce), .wr_checksum_val(wcv), .wr_delay(wd),
		.wr_delay_val(wdv), .wr_switch(ws), .wr_switch_val(wsv),
		.wr_clear(wcl), .wr_clear_mask(wcm), .latch_disable(ld),
		.error_pin_en(pe), .clk_mode(cm), .general_pin_six_in(g6),
		.flags(fl), .busy_flag(bz), .error_pin(ep), .switches(sw),
		.checksum_en(ce), .suppress_delay(sd), .general_pin_six_out(g6o),
		.general_pin_six_oe(g6e), .timing_tick(tk));
	sief_host_model host (.clk, .go, .mask(msk), .wr_clear(wcl),
		.wr_clear_mask(wcm));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	task tally_and_finish();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	task chk(string s, logic [7:0] a, logic [7:0] e);
		total_checks++;
		if (a !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", s, e, a);
		end
	endtask : chk
	task w(int k);
		repeat (k) @(negedge clk);
	endtask : w
	task sn(int i, logic v);
		@(negedge clk);
		sv[i] = v;
		w(12);
	endtask : sn
	task clr(logic [5:0] m);
		@(negedge clk);
		go = 1'b1;
		msk = m;
		@(negedge clk);
		go = 1'b0;
		w(3);
	endtask : clr
	task wrs(logic [4:0] v);
		@(negedge clk);
		ws = 1'b1;
		wsv = v;
		@(negedge clk);
		ws = 1'b0;
	endtask : wrs
	task wrd(logic [7:0] v);
		@(negedge clk);
		wd = 1'b1;
		wdv = v;
		@(negedge clk);
		wd = 1'b0;
	endtask : wrd

	initial begin
		{cb, iso, srst, wce, wcv, wd, ws, ld, g6, go} = '0;
		pe = 1'b1;
		wdv = 8'h00;
		wsv = 5'h00;
		sv = 5'h00;
		msk = 6'h00;
		ef = 6'h00;
		cm = SIEF_CLK_INTERNAL;
		rst = 1'b1;
		w(8);
		rst = 1'b0;
		w(1);
		chk("flags", fl, 8'h00);
		chk("cksum_en", ce, 8'h00);
		for (int i = 0; i < 5; i++) begin
			wrs(5'h01 << i);
			chk("switches", sw, 8'h01 << i);
		end
		n = $random(seed);
		wrs(n[4:0]);
		chk("switches", sw, n[4:0]);
		n = $random(seed);
		wrd(n[7:0]);
		chk("delay", sd, n[7:0]);
		wrd(8'h00);
		for (int i = 0; i < 5; i++) begin
			sn(i, 1'b1);
			sn(i, 1'b0);
			ef[i] = 1'b1;
			chk("flags", fl, ef);
			chk("err_pin", ep, 8'h01);
		end
		clr(6'h01);
		ef[0] = 1'b0;
		chk("flags", fl, ef);
		pe = 1'b0;
		w(3);
		chk("err_pin", ep, 8'h00);
		pe = 1'b1;
		clr(6'h3f);
		chk("err_pin", ep, 8'h00);
		sn(0, 1'b1);
		clr(6'h01);
		chk("flags", fl, 8'h01);
		sn(0, 1'b0);
		clr(6'h01);
		ld = 1'b1;
		sn(1, 1'b1);
		chk("flags", fl, 8'h02);
		sn(1, 1'b0);
		chk("flags", fl, 8'h00);
		ld = 1'b0;
		iso = 1'b1;
		w(12);
		chk("busy", bz, 8'h01);
		sn(2, 1'b1);
		chk("flags", fl, 8'h00);
		sn(2, 1'b0);
		iso = 1'b0;
		w(12);
		chk("busy", bz, 8'h00);
		cb = 1'b1;
		w(12);
		chk("flags", fl, 8'h00);
		wce = 1'b1;
		wcv = 1'b1;
		w(1);
		wce = 1'b0;
		w(12);
		chk("flags", fl, 8'h20);
		cb = 1'b0;
		srst = 1'b1;
		w(1);
		srst = 1'b0;
		w(2);
		chk("cksum_en", ce, 8'h00);
		clr(6'h3f);
		wrd(8'h02);
		sn(3, 1'b1);
		chk("flags", fl, 8'h00);
		w(700);
		chk("flags", fl, 8'h08);
		sn(3, 1'b0);
		cm = SIEF_CLK_DRIVE_OUT;
		w(300);
		chk("pin6_oe", g6e, 8'h01);
		n = 0;
		m = 0;
		p = g6o;
		for (int k = 0; k < 2000; k++) begin
			@(negedge clk);
			n += tk;
			if (g6o !== p)
				m++;
			p = g6o;
		end
		chk("int_ticks", n > 8 && n < 12, 8'h01);
		chk("pin6_out", m > 37 && m < 43, 8'h01);
		cm = SIEF_CLK_EXTERNAL;
		n = 0;
		for (int k = 0; k < 2800; k++) begin
			@(negedge clk);
			if (k % 20 == 0)
				g6 = ~g6;
			if (k >= 800)
				n += tk;
		end
		chk("pin6_oe", g6e, 8'h00);
		chk("ext_ticks", n > 23 && n < 27, 8'h01);
		tally_and_finish();
	end
endmodule : tb_top

/* verilog/sief_core.sv */
// error flag capture, error pin, diagnostic switches and timing clock
// assumes sensor and pin inputs are asynchronous; port writes are on clk
`timescale 1ns/10ps
module sief_core
	import sief_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire sief_sense_s          sense_raw,
	input  wire logic                 checksum_bad,
	input  wire logic                 isolation_stage_active,
	input  wire logic                 soft_reset_command,
	input  wire logic                 wr_checksum_en,
	input  wire logic                 wr_checksum_val,
	input  wire logic                 wr_delay,
	input  wire logic [DELAY_W-1:0]   wr_delay_val,
	input  wire logic                 wr_switch,
	input  wire sief_switch_s         wr_switch_val,
	input  wire logic                 wr_clear,
	input  wire logic [SENSE_W-1:0]   wr_clear_mask,
	input  wire logic                 latch_disable,
	input  wire logic                 error_pin_en,
	input  wire sief_clkmode_e        clk_mode,
	input  wire logic                 general_pin_six_in,
	output logic [SENSE_W-1:0]        flags,
	output logic                      busy_flag,
	output logic                      error_pin,
	output sief_switch_s              switches,
	output logic                      checksum_en,
	output logic [DELAY_W-1:0]        suppress_delay,
	output logic                      general_pin_six_out,
	output logic                      general_pin_six_oe,
	output logic                      timing_tick
);
	// three-stage synchronisers for everything from outside the domain
	localparam int unsigned NS = SENSE_W + 2;

	logic [NS-1:0]        s1_ff;
	logic [NS-1:0]        s2_ff;
	logic [NS-1:0]        s3_ff;
	logic [NS-1:0]        stable_ff;
	logic [SENSE_W-1:0]   flags_ff;
	logic [SENSE_W-1:0]   nxt_flags;
	logic [SENSE_W-1:0]   filt;
	logic [SENSE_W-1:0]   sensed;
	logic [SENSE_W-1:0]   clr;
	logic                 busy_ff;
	logic                 err_ff;
	sief_switch_s         sw_ff;
	logic                 cks_ff;
	logic [DELAY_W-1:0]   delay_ff;
	logic                 osc_ff;
	logic [15:0]          osc_cnt_ff;
	logic                 div_ff;
	logic                 src_prev_ff;
	logic                 tick_ff;
	logic                 pin_out_ff;
	logic                 pin_oe_ff;
	wire  [NS-1:0]        raw_in = {general_pin_six_in, isolation_stage_active,
		checksum_bad, sense_raw};

	// a change counts once stages two and three agree
	wire  [NS-1:0]        agree = ~(s2_ff ^ s3_ff);
	wire  [NS-1:0]        nxt_stable = (agree & s3_ff) | (~agree & stable_ff);

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_ff     <= '0;
			s2_ff     <= '0;
			s3_ff     <= '0;
			stable_ff <= '0;
		end else begin
			s1_ff     <= raw_in;
			s2_ff     <= s1_ff;
			s3_ff     <= s2_ff;
			stable_ff <= nxt_stable;
		end
	end

	wire iso_on  = stable_ff[SENSE_W];
	wire ext_clk = stable_ff[SENSE_W+1];

	// internal oscillator model, divided from clk
	wire osc_wrap = (osc_cnt_ff == 16'(OSC_HALF_CYC - 1));

	always_ff @(posedge clk) begin
		if (rst) begin
			osc_cnt_ff <= '0;
			osc_ff     <= 1'b0;
		end else begin
			osc_cnt_ff <= osc_wrap ? '0 : osc_cnt_ff + 16'h0001; // R13
			osc_ff     <= osc_wrap ? ~osc_ff : osc_ff; // R13
		end
	end

	// external clock replaces the internal one when selected
	wire use_ext = (clk_mode == SIEF_CLK_EXTERNAL); // R14
	wire src_clk = use_ext ? ext_clk : osc_ff; // R14
	wire src_rise = src_clk && !src_prev_ff;
	// dividing by two on rising edges makes duty cycle irrelevant
	wire nxt_div = src_rise ? ~div_ff : div_ff; // R15

	always_ff @(posedge clk) begin
		if (rst) begin
			src_prev_ff <= 1'b0;
			div_ff      <= 1'b0;
			tick_ff     <= 1'b0;
			pin_out_ff  <= 1'b0;
			pin_oe_ff   <= 1'b0;
		end else begin
			src_prev_ff <= src_clk;
			div_ff      <= nxt_div;
			tick_ff     <= src_rise && div_ff; // R15
			pin_out_ff  <= osc_ff; // R13
			pin_oe_ff   <= (clk_mode == SIEF_CLK_DRIVE_OUT); // R13
		end
	end

	// configuration written only over the port
	wire cks_kill = soft_reset_command; // R20

	always_ff @(posedge clk) begin
		if (rst) begin
			cks_ff   <= 1'b0; // R20
			delay_ff <= DELAY_RST;
			sw_ff    <= SW_RST;
		end else begin
			if (cks_kill)
				cks_ff <= 1'b0; // R20
			else if (wr_checksum_en)
				cks_ff <= wr_checksum_val;
			if (wr_delay)
				delay_ff <= wr_delay_val; // R4
			if (wr_switch)
				sw_ff <= wr_switch_val; // R11 R12
		end
	end

	for (genvar i = 0; i < SENSE_W; i++) begin : g_filt
		sief_filter #(
			.DW (DELAY_W)
		) u_filt (
			.clk   (clk),
			.rst   (rst),
			.tick  (tick_ff),
			.delay (delay_ff),
			.raw   (stable_ff[i]),
			.filt  (filt[i])
		);
	end

	// sensor mapping: struct order matches flag bit positions
	// R6 R7 R8 R9 R19: each filtered sensor feeds its own flag bit
	// checksum sense is forced off unless checksum mode runs
	wire [SENSE_W-1:0] cks_gate = {cks_ff, {(SENSE_W-1){1'b1}}}; // R10
	assign sensed = filt & cks_gate & {SENSE_W{!iso_on}}; // R5 R10
	assign clr    = wr_clear ? wr_clear_mask : '0; // R17
	// set wins over clear in the same cycle
	assign nxt_flags = latch_disable ? sensed : // R3
		((flags_ff & ~clr) | sensed); // R1 R16 R17

	always_ff @(posedge clk) begin
		if (rst) begin
			flags_ff <= FLAGS_RST;
			busy_ff  <= 1'b0;
			err_ff   <= 1'b0;
		end else begin
			flags_ff <= nxt_flags;
			busy_ff  <= iso_on; // R18
			err_ff   <= error_pin_en && (|nxt_flags); // R2
		end
	end

	assign flags               = flags_ff;
	assign busy_flag           = busy_ff;
	assign error_pin           = err_ff;
	assign switches            = sw_ff;
	assign checksum_en         = cks_ff;
	assign suppress_delay      = delay_ff;
	assign general_pin_six_out = pin_out_ff;
	assign general_pin_six_oe  = pin_oe_ff;
	assign timing_tick         = tick_ff;

	a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
		!latch_disable && flags_ff[0] && !(wr_clear && wr_clear_mask[0])
		|=> flags_ff[0]) // R1
		else $error("latched flag lost without clear");
	a_set_beats_clr: assert property (@(posedge clk) disable iff (rst)
		sensed[1] |=> flags_ff[1]) // R16
		else $error("present condition cleared");
	a_clear_works: assert property (@(posedge clk) disable iff (rst)
		wr_clear && wr_clear_mask[2] && !sensed[2] |=> !flags_ff[2]) // R17
		else $error("write one did not clear flag");
	a_follow_mode: assert property (@(posedge clk) disable iff (rst)
		latch_disable |=> flags_ff == $past(sensed)) // R3
		else $error("flags not following sensors");
	a_iso_masks: assert property (@(posedge clk) disable iff (rst)
		iso_on |-> sensed == '0) // R5
		else $error("sensor passed during isolation");
	a_cks_gated: assert property (@(posedge clk) disable iff (rst)
		!cks_ff && !$past(cks_ff) && latch_disable |-> !flags_ff[B_CHECKSUM])
		// R10
		else $error("checksum flag with checksum off");
	// pin follows next flags, so the enable seen one edge earlier decides
	a_err_pin: assert property (@(posedge clk) disable iff (rst)
		error_pin_en && (|nxt_flags) |=> error_pin) // R2
		else $error("error pin low with flags set");
	a_pin_oe: assert property (@(posedge clk) disable iff (rst)
		general_pin_six_oe == ($past(clk_mode) == SIEF_CLK_DRIVE_OUT)) // R13
		else $error("pin six enable does not follow mode");
	a_tick_pulse: assert property (@(posedge clk) disable iff (rst)
		tick_ff |=> !tick_ff) // R15
		else $error("timing tick longer than one cycle");
	a_soft_rst: assert property (@(posedge clk) disable iff (rst)
		soft_reset_command |=> !cks_ff) // R20
		else $error("checksum mode survived soft reset");
	a_busy_track: assert property (@(posedge clk) disable iff (rst)
		busy_flag == $past(iso_on)) // R18
		else $error("busy bit not tracking isolation");

	c_flag_set: cover property (@(posedge clk) disable iff (rst)
		!flags_ff[B_CLAMP] ##1 flags_ff[B_CLAMP]);
	c_flag_clear: cover property (@(posedge clk) disable iff (rst)
		flags_ff[B_GAIN] ##1 !flags_ff[B_GAIN]);
	c_ext_tick: cover property (@(posedge clk) disable iff (rst)
		use_ext && tick_ff);
	c_cks_flag: cover property (@(posedge clk) disable iff (rst)
		flags_ff[B_CHECKSUM]);

endmodule : sief_core

/* verilog/sief_filter.sv */
// per-sensor suppression delay filter on the divided timing tick
// assumes sensor inputs already synchronised to clk
`timescale 1ns/10ps
module sief_filter
	import sief_pkg::*;
#(
	parameter int unsigned DW = DELAY_W
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          tick,
	input  wire logic [DW-1:0] delay,
	input  wire logic          raw,
	output logic               filt
);
	logic [DW-1:0] cnt_ff;
	logic [DW-1:0] nxt_cnt;
	logic          filt_ff;
	wire           reached = (cnt_ff >= delay);

	// condition must hold for delay ticks; any drop restarts the wait
	assign nxt_cnt = !raw ? '0 :
		(tick && !reached) ? cnt_ff + 1'b1 : cnt_ff; // R4

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_ff  <= '0;
			filt_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			filt_ff <= raw && reached; // R4
		end
	end

	assign filt = filt_ff;

	a_filter_drop: assert property (@(posedge clk) disable iff (rst)
		!raw |=> !filt) // R4
		else $error("filter output high after sensor dropped");

endmodule : sief_filter
